// File: verif/msc_bus_peer.sv
// behavioural slave on the two-wire bus, partner of the sequence control block
`timescale 1ns/1ps
module msc_bus_peer
(
  // clock and line levels
  input  wire       clk_i,
  input  wire       scl_i,
  input  wire       sda_i,
  // behaviour and observation
  input  wire       nack_i,
  input  wire [7:0] tx_byte_i,
  output reg        sda_oe_o   = 1'b0,
  output reg  [7:0] rx_byte_o  = 8'h00,
  output reg        ack_seen_o = 1'b0,
  output reg  [7:0] starts_o   = 8'h00,
  output reg  [7:0] stops_o    = 8'h00
);
  reg       scl_q = 1'b1;
  reg       sda_q = 1'b1;
  reg       first = 1'b0;
  reg       rd    = 1'b0;
  reg [3:0] cnt   = 4'h0;
  always @(posedge clk_i)
  begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (scl_i && scl_q && sda_q && !sda_i)
    begin
      cnt      <= 4'h0;
      first    <= 1'b1;
      rd       <= 1'b0;
      sda_oe_o <= 1'b0;
      starts_o <= starts_o + 8'h01;
    end
    else if (scl_i && scl_q && !sda_q && sda_i)
    begin
      rd       <= 1'b0;
      sda_oe_o <= 1'b0;
      stops_o  <= stops_o + 8'h01;
    end
    else if (scl_i && !scl_q)
    begin
      if (cnt == 4'h8)
        ack_seen_o <= sda_i;
      else
        rx_byte_o <= {rx_byte_o[6:0], sda_i};
      cnt <= cnt + 4'h1;
    end
    else if (!scl_i && scl_q)
    begin
      // data changes only while the clock is low
      if (cnt == 4'h8)
        sda_oe_o <= !rd && !nack_i;
      else if (cnt == 4'h9)
      begin
        cnt      <= 4'h0;
        first    <= 1'b0;
        rd       <= first ? rx_byte_o[0] : (rd && !ack_seen_o);
        sda_oe_o <= (first ? rx_byte_o[0] : (rd && !ack_seen_o)) && !tx_byte_i[7];
      end
      else
        sda_oe_o <= rd && cnt != 4'h0 && !tx_byte_i[3'h7 - cnt[2:0]];
    end
  end
endmodule // msc_bus_peer

// File: verif/msc_seq_ctrl_props.sv
// port assertions of the sequence control block
`timescale 1ns/1ps
`include "msc_defines.vh"
module msc_props
(
  // watched ports
  input wire        clk_i,
  input wire        sys_rst_i,
  input wire        hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire [31:0] hwdata_i,
  input wire        hready_i,
  input wire [31:0] hrdata_o,
  input wire        hreadyout_o,
  input wire        hresp_o,
  input wire        scl_o,
  input wire        scl_oe_o,
  input wire        sda_o,
  input wire        sda_oe_o,
  input wire        irq_o
);
  reg       rd_q;
  reg       wm_q;
  reg [7:0] addr_q;
  wire      take = hsel_i && htrans_i[1] && hready_i;
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rd_q   <= 1'b0;
      wm_q   <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      rd_q   <= take && !hwrite_i;
      wm_q   <= take && hwrite_i && haddr_i[9:2] == `MSC_OFF_IRQ_MASK;
      addr_q <= haddr_i[9:2];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_ready_high: assert property (hreadyout_o) else $error("wait state inserted");
  a_resp_okay: assert property (!hresp_o) else $error("error response given");
  a_lines_low: assert property (!scl_o && !sda_o) else $error("line driven high");
  a_rdata_idle: assert property (!rd_q |-> hrdata_o == 32'h0000_0000)
    else $error("read data outside a read");
  a_rdata_byte: assert property (rd_q |-> hrdata_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (rd_q && addr_q == 8'h30 |-> hrdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (wm_q && hwdata_i[2:0] == 3'b000 |-> ##2 !irq_o)
    else $error("interrupt despite full mask");
  a_edge_apart: assert property ($changed(sda_oe_o) |-> $stable(scl_oe_o))
    else $error("data and clock moved together");
endmodule // msc_props
bind msc_seq_ctrl msc_props u_props
(
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o)
);

// File: verif/tb.sv
// self-checking bench of the two-wire bus master sequence control block
`timescale 1ns/1ps
`include "msc_defines.vh"
module tb;
  reg         clk_i      = 1'b0;
  reg         sys_rst_i  = 1'b1;
  reg         hsel       = 1'b0;
  reg  [31:0] haddr      = 32'h0000_0000;
  reg  [1:0]  htrans     = 2'b00;
  reg         hwrite     = 1'b0;
  reg  [31:0] hwdata     = 32'h0000_0000;
  reg         nack       = 1'b0;
  reg         t_scl_oe   = 1'b0;
  reg         t_sda_oe   = 1'b0;
  reg  [31:0] r;
  reg  [15:0] hi_cnt     = 16'h0000;
  reg  [15:0] last_hi    = 16'h0000;
  integer     mismatches = 0;
  integer     checked    = 0;
  wire [31:0] hrdata;
  wire [7:0]  rx_byte, starts, stops;
  wire        hready, scl_o, scl_oe, sda_o, sda_oe, p_sda_oe, ack_seen, irq;
  // open-drain lines with pull-ups
  wire        scl = (scl_oe ? scl_o : 1'b1) && !t_scl_oe;
  wire        sda = (sda_oe ? sda_o : 1'b1) && !p_sda_oe && !t_sda_oe;
  msc_seq_ctrl dut
  (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(), .scl_i(scl), .scl_o(scl_o),
    .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .irq_o(irq)
  );
  msc_bus_peer peer
  (
    .clk_i(clk_i), .scl_i(scl), .sda_i(sda), .nack_i(nack), .tx_byte_i(8'h3c),
    .sda_oe_o(p_sda_oe), .rx_byte_o(rx_byte), .ack_seen_o(ack_seen), .starts_o(starts),
    .stops_o(stops)
  );
  initial forever #2.5 clk_i = ~clk_i;
  // length of the last released stretch of the clock line, in clock cycles
  always @(posedge clk_i)
  begin
    if (!scl_oe)
      hi_cnt <= hi_cnt + 16'h0001;
    else
    begin
      if (hi_cnt != 16'h0000)
        last_hi <= hi_cnt;
      hi_cnt <= 16'h0000;
    end
  end
  // ----------------------------------------
  // bus cycles and comparison
  // ----------------------------------------
  task check(input [7:0] seen, input [7:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task ahb(input [7:0] a, input w, input [7:0] d);
    begin
      @(posedge clk_i);
      hsel   <= 1'b1;
      haddr  <= {22'h00_0000, a, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge clk_i);
      while (hready !== 1'b1) @(posedge clk_i);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, d};
      @(posedge clk_i);
      while (hready !== 1'b1) @(posedge clk_i);
      r = hrdata;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d); ahb(a, 1'b1, d); endtask
  task rd(input [7:0] a); ahb(a, 1'b0, 8'h00); endtask
  task wait_idle;
    integer n;
    begin
      for (n = 0; n < 500; n = n + 1)
      begin
        rd(`MSC_OFF_STATUS);
        if (r[2] === 1'b0)
        begin
          rd(`MSC_OFF_SEQ);
          if (r[4:0] === 5'h00)
            n = 999;
        end
      end
      check({7'h00, n != 1000}, 8'h00);
    end
  endtask
  // second master on the bus, used to send a general call
  task ext_master(input [7:0] b);
    integer i;
    reg [8:0] v;
    begin
      v = {b, 1'b1};
      t_sda_oe <= 1'b1;
      repeat (20) @(posedge clk_i);
      for (i = 0; i < 9; i = i + 1)
      begin
        t_scl_oe <= 1'b1;
        repeat (10) @(posedge clk_i);
        t_sda_oe <= !v[8 - i];
        repeat (10) @(posedge clk_i);
        t_scl_oe <= 1'b0;
        repeat (20) @(posedge clk_i);
      end
      t_scl_oe <= 1'b1;
      t_sda_oe <= 1'b1;
      repeat (10) @(posedge clk_i);
      t_scl_oe <= 1'b0;
      repeat (10) @(posedge clk_i);
      t_sda_oe <= 1'b0;
      repeat (20) @(posedge clk_i);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    begin
      rd(`MSC_OFF_SEQ);
      check(r[7:0], 8'h00);
      wr(`MSC_OFF_SEQ, 8'hbf);
      rd(`MSC_OFF_SEQ);
      check(r[7:0], 8'ha0);
      wr(`MSC_OFF_SEQ, 8'h00);
      rd(8'h30);
      check(r[7:0], 8'h00);
    end
  endtask
  task t_write;
    begin
      wr(`MSC_OFF_MODE, 8'h08);
      wr(`MSC_OFF_BAUD, 8'h01);
      wr(`MSC_OFF_IRQ_MASK, 8'h04);
      wr(`MSC_OFF_SEQ, 8'h01);
      wait_idle;
      check(starts, 8'h01);
      wr(`MSC_OFF_DATA, 8'ha4);
      wr(`MSC_OFF_DATA, 8'h55);
      wait_idle;
      check(rx_byte, 8'ha4);
      // reload 1: bus clock period 4 * 2 cycles, high half 4 cycles
      check(last_hi[7:0], 8'h04);
      rd(`MSC_OFF_SEQ);
      check(r[7:0] & 8'h40, 8'h00);
      rd(`MSC_OFF_MODE);
      check(r[7:0], 8'h88);
      check({7'h00, irq}, 8'h01);
      wr(`MSC_OFF_IRQ_MASK, 8'h00);
      rd(`MSC_OFF_IRQ_STAT);
      check({7'h00, irq}, 8'h00);
      wr(`MSC_OFF_IRQ_STAT, 8'h07);
      rd(`MSC_OFF_IRQ_STAT);
      check(r[7:0] & 8'h04, 8'h00);
      wr(`MSC_OFF_MODE, 8'h08);
      nack <= 1'b1;
      wr(`MSC_OFF_DATA, 8'h55);
      wr(`MSC_OFF_SEQ, 8'h04);
      wait_idle;
      check(stops, 8'h00);
      rd(`MSC_OFF_SEQ);
      check(r[7:0] & 8'h40, 8'h40);
      nack <= 1'b0;
      wr(`MSC_OFF_SEQ, 8'h04);
      wait_idle;
      check(stops, 8'h01);
    end
  endtask
  task t_read;
    begin
      wr(`MSC_OFF_SEQ, 8'h01);
      wait_idle;
      wr(`MSC_OFF_DATA, 8'ha5);
      wait_idle;
      wr(`MSC_OFF_SEQ, 8'h08);
      rd(`MSC_OFF_SEQ);
      check(r[7:0] & 8'h08, 8'h08);
      wait_idle;
      rd(`MSC_OFF_STATUS);
      check(r[7:0] & 8'h01, 8'h01);
      rd(`MSC_OFF_DATA);
      check(r[7:0], 8'h3c);
      wr(`MSC_OFF_SEQ, 8'h10);
      wait_idle;
      check({7'h00, ack_seen}, 8'h00);
      wr(`MSC_OFF_SEQ, 8'h08);
      wait_idle;
      wr(`MSC_OFF_SEQ, 8'h30);
      wait_idle;
      check({7'h00, ack_seen}, 8'h01);
      rd(`MSC_OFF_SEQ);
      check(r[7:0] & 8'h30, 8'h20);
      wr(`MSC_OFF_SEQ, 8'h02);
      wait_idle;
      check(starts, 8'h03);
      wr(`MSC_OFF_SEQ, 8'h04);
      wait_idle;
      check(stops, 8'h02);
    end
  endtask
  task t_gcall;
    begin
      wr(`MSC_OFF_MODE, 8'h06);
      wr(`MSC_OFF_SEQ, 8'h80);
      wr(`MSC_OFF_IRQ_STAT, 8'h07);
      wr(`MSC_OFF_IRQ_MASK, 8'h02);
      ext_master(8'h00);
      rd(`MSC_OFF_IRQ_STAT);
      check(r[7:0] & 8'h02, 8'h02);
      check({7'h00, irq}, 8'h01);
      wr(`MSC_OFF_IRQ_STAT, 8'h07);
      wr(`MSC_OFF_SEQ, 8'h00);
      ext_master(8'h00);
      rd(`MSC_OFF_IRQ_STAT);
      check(r[7:0] & 8'h02, 8'h00);
      check({7'h00, irq}, 8'h00);
    end
  endtask
  task complete_run;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs;
    t_write;
    t_read;
    t_gcall;
    complete_run;
  end
  // the whole run needs a few thousand cycles; this cuts a hang short
  initial
  begin
    #300000;
    mismatches = mismatches + 1;
    complete_run;
  end
endmodule // tb

// File: verilog/msc_defines.vh
// constants and register layout of the two-wire bus master sequence control block
// ------------------------------------------------------------------------------
// How it works
// - slave mode with general call enabled interrupts on all-zero address received
// - ack status reads one when slave did not acknowledge last byte
// - ack value bit sets level driven in acknowledge sequence; one is not-ack
// - ack sequence bit launches acknowledge sequence, hardware clears it when done
// - receive bit in master mode enters receive mode; clear means idle
// - stop bit generates stop condition, cleared by hardware on completion
// - repeated start bit generates repeated start, cleared by hardware on completion
// - start bit generates start condition, cleared by hardware on completion
// - while not idle, sequence bit sets and buffer writes are refused, not queued
// - every control bit readable, writable by software, zero after reset; go bits take writes only in master mode
// - idle only when transmit flag and all sequence bits are clear
// - master mode is code 1000; bus clock is clock over four times reload plus one
// - buffer write in master mode when transmission cannot begin sets write collision flag
// ------------------------------------------------------------------------------
`ifndef MSC_DEFINES_VH
`define MSC_DEFINES_VH
`define MSC_ADDR_W          8
// offsets are word indices: one register to a word, byte address is four times the index
`define MSC_OFF_MODE        8'h11
`define MSC_OFF_SEQ         8'h12
`define MSC_OFF_STATUS      8'h13
`define MSC_OFF_BAUD        8'h14
`define MSC_OFF_DATA        8'h18
`define MSC_OFF_SLV_ADDR    8'h1c
`define MSC_OFF_IRQ_STAT    8'h20
`define MSC_OFF_IRQ_MASK    8'h24
`define MSC_MODE_MASTER     4'h8
`define MSC_MODE_SLAVE7     4'h6
`define MSC_BIT_GCE         7
`define MSC_BIT_ACK_STATUS_FLAG     6
`define MSC_BIT_ACKVAL      5
`define MSC_BIT_ACKGO       4
`define MSC_BIT_RXGO        3
`define MSC_BIT_STOPGO      2
`define MSC_BIT_RSGO        1
`define MSC_BIT_STARTGO     0
`define MSC_SEQ_RESET       8'h00
`define MSC_BAUD_RESET      8'h00
`define MSC_IRQ_DONE        0
`define MSC_IRQ_GCALL       1
`define MSC_IRQ_WRITE_COLLISION_FLAG        2
`define MSC_IRQ_W           3
`endif

// File: verilog/msc_seq_ctrl.v
// two-wire bus master sequence control with ahb-lite register slave
`timescale 1ns/1ps
`include "msc_defines.vh"
module msc_seq_ctrl
(
  // clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // ahb-lite slave
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  // two-wire bus, open drain
  input  wire        scl_i,
  output reg         scl_o,
  output reg         scl_oe_o,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe_o,
  // interrupt
  output reg         irq_o
);

  // ----------------------------------------------------------------------------
  // states of the sequence engine
  // ----------------------------------------------------------------------------
  localparam [3:0] ST_IDLE  = 4'd0;
  localparam [3:0] ST_START = 4'd1;
  localparam [3:0] ST_RSTRT = 4'd2;
  localparam [3:0] ST_STOP  = 4'd3;
  localparam [3:0] ST_ACK   = 4'd4;
  localparam [3:0] ST_RX    = 4'd5;
  localparam [3:0] ST_TX    = 4'd6;
  localparam [3:0] ST_SLAVE = 4'd7;

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg       sda_last_reg;
  reg       scl_last_reg;
  wire      scl_s = scl_sync_reg[1];
  wire      sda_s = sda_sync_reg[1];

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      sda_last_reg <= 1'b1;
      scl_last_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      sda_last_reg <= sda_s;
      scl_last_reg <= scl_s;
    end
  end

  wire bus_start = scl_s & sda_last_reg & ~sda_s;
  wire scl_rise  = scl_s & ~scl_last_reg;

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  reg [7:0]  mode_reg;
  reg [7:0]  seq_reg;
  reg [7:0]  baud_reg;
  reg [7:0]  data_reg;
  reg [6:0]  slv_addr_reg;
  reg        buf_full_reg;
  reg        write_collision_flag_reg;
  reg [`MSC_IRQ_W-1:0] irq_stat_reg;
  reg [`MSC_IRQ_W-1:0] irq_mask_reg;

  // engine
  reg [3:0]  state_reg;
  reg [1:0]  phase_reg;
  reg [3:0]  bit_cnt_reg;
  reg [7:0]  baud_cnt_reg;
  reg [7:0]  shift_reg;
  reg        rx_tick_reg;

  // ahb address phase capture
  reg        wr_pend_reg;
  reg [7:0]  wr_addr_reg;

  wire master_mode = (mode_reg[3:0] == `MSC_MODE_MASTER);
  wire slave_mode  = (mode_reg[3:0] == `MSC_MODE_SLAVE7);
  wire tx_busy     = (state_reg == ST_TX);
  // transmit flag or-ed with every sequence bit gives busy
  wire engine_idle = ~tx_busy & (seq_reg[4:0] == 5'b0_0000);

  // baud tick: clock / (4 * (reload + 1)) per bus clock, one tick a quarter
  wire baud_tick = (baud_cnt_reg == baud_reg);

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      baud_cnt_reg <= `MSC_BAUD_RESET;
    else if (baud_tick || state_reg == ST_IDLE)
      baud_cnt_reg <= 8'h00;
    else
      baud_cnt_reg <= baud_cnt_reg + 8'h01;
  end

  function [7:0] sel_bit;
    input [2:0] idx;
    begin
      sel_bit = 8'h01 << idx;
    end
  endfunction

  // ----------------------------------------------------------------------------
  // ahb-lite slave: zero wait states, always okay
  // ----------------------------------------------------------------------------
  // haddr bits 9:2 give the register index, so odd printed offsets stay word aligned
  wire       ahb_go   = hsel_i & htrans_i[1] & hready_i;
  wire       wr_now   = wr_pend_reg;
  wire [7:0] wdat     = hwdata_i[7:0];
  wire       wr_seq   = wr_now && (wr_addr_reg == `MSC_OFF_SEQ);
  wire       wr_data  = wr_now && (wr_addr_reg == `MSC_OFF_DATA);
  wire       wr_istat = wr_now && (wr_addr_reg == `MSC_OFF_IRQ_STAT);
  // a write to the sequence bits starts the engine only when idle
  wire       seq_ok   = engine_idle & master_mode;
  wire       data_ok  = engine_idle & master_mode;

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= ahb_go & hwrite_i;
      wr_addr_reg <= haddr_i[9:2];
      hrdata_o    <= 32'h0000_0000;
      if (ahb_go && !hwrite_i)
      begin
        case (haddr_i[9:2])
          `MSC_OFF_MODE:     hrdata_o <= {24'h00_0000, write_collision_flag_reg, 3'b000, mode_reg[3:0]};
          `MSC_OFF_SEQ:      hrdata_o <= {24'h00_0000, seq_reg};
          `MSC_OFF_STATUS:   hrdata_o <= {24'h00_0000, 5'b0_0000, tx_busy, 1'b0,
                                          buf_full_reg};
          `MSC_OFF_BAUD:     hrdata_o <= {24'h00_0000, baud_reg};
          `MSC_OFF_DATA:     hrdata_o <= {24'h00_0000, data_reg};
          `MSC_OFF_SLV_ADDR: hrdata_o <= {25'h000_0000, slv_addr_reg};
          `MSC_OFF_IRQ_STAT: hrdata_o <= {28'h000_0000, 1'b0, irq_stat_reg};
          `MSC_OFF_IRQ_MASK: hrdata_o <= {28'h000_0000, 1'b0, irq_mask_reg};
          default:           hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // sequence engine
  // ----------------------------------------------------------------------------
  reg        done_ev;
  reg        gcall_ev;
  reg        write_collision_flag_ev;
  reg [7:0]  seq_clr;
  // a finished go bit clears one cycle late; masking it keeps the engine from a second run
  wire [7:0] seq_live = seq_reg & ~seq_clr;

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_reg    <= ST_IDLE;
      phase_reg    <= 2'd0;
      bit_cnt_reg  <= 4'd0;
      shift_reg    <= 8'h00;
      scl_o        <= 1'b0;
      scl_oe_o     <= 1'b0;
      sda_o        <= 1'b0;
      sda_oe_o     <= 1'b0;
      done_ev      <= 1'b0;
      gcall_ev     <= 1'b0;
      seq_clr      <= 8'h00;
      rx_tick_reg  <= 1'b0;
    end
    else
    begin
      done_ev  <= 1'b0;
      gcall_ev <= 1'b0;
      seq_clr  <= 8'h00;
      rx_tick_reg <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          phase_reg <= 2'd0;
          bit_cnt_reg <= 4'd0;
          if (slave_mode)
            state_reg <= ST_SLAVE;
          else if (seq_live[`MSC_BIT_STARTGO])
            state_reg <= ST_START;
          else if (seq_live[`MSC_BIT_RSGO])
            state_reg <= ST_RSTRT;
          else if (seq_live[`MSC_BIT_STOPGO])
            state_reg <= ST_STOP;
          else if (seq_live[`MSC_BIT_ACKGO])
            state_reg <= ST_ACK;
          else if (seq_live[`MSC_BIT_RXGO])
            state_reg <= ST_RX;
          else if (wr_data && data_ok)
          begin
            state_reg <= ST_TX;
            shift_reg <= wdat;
          end
        end
        // start: sda falls while scl high, then scl low
        ST_START, ST_RSTRT:
          if (baud_tick)
          begin
            phase_reg <= phase_reg + 2'd1;
            case (phase_reg)
              2'd0:
              begin
                sda_oe_o <= 1'b0;
                scl_oe_o <= (state_reg == ST_RSTRT);
              end
              2'd1: scl_oe_o <= 1'b0;
              2'd2: sda_oe_o <= 1'b1;
              default:
              begin
                scl_oe_o  <= 1'b1;
                state_reg <= ST_IDLE;
                done_ev   <= 1'b1;
                // hardware clears the go bit on completion
                seq_clr   <= (state_reg == ST_START) ? sel_bit(`MSC_BIT_STARTGO)
                                                     : sel_bit(`MSC_BIT_RSGO);
              end
            endcase
          end
        // stop: sda low, release scl, then release sda while scl high
        ST_STOP:
          if (baud_tick)
          begin
            phase_reg <= phase_reg + 2'd1;
            case (phase_reg)
              2'd0: sda_oe_o <= 1'b1;
              2'd1: scl_oe_o <= 1'b0;
              2'd2: sda_oe_o <= 1'b0;
              default:
              begin
                state_reg <= ST_IDLE;
                done_ev   <= 1'b1;
                seq_clr   <= sel_bit(`MSC_BIT_STOPGO);
              end
            endcase
          end
        // ack: drive ack value during one scl high pulse
        ST_ACK:
          if (baud_tick)
          begin
            phase_reg <= phase_reg + 2'd1;
            case (phase_reg)
              2'd0: sda_oe_o <= ~seq_reg[`MSC_BIT_ACKVAL];
              2'd1: scl_oe_o <= 1'b0;
              2'd2: scl_oe_o <= 1'b1;
              default:
              begin
                sda_oe_o  <= 1'b0;
                state_reg <= ST_IDLE;
                done_ev   <= 1'b1;
                seq_clr   <= sel_bit(`MSC_BIT_ACKGO);
              end
            endcase
          end
        // receive and transmit: one bit per four baud ticks
        ST_RX, ST_TX:
          if (baud_tick)
          begin
            phase_reg <= phase_reg + 2'd1;
            case (phase_reg)
              2'd0: sda_oe_o <= (state_reg == ST_TX) && (bit_cnt_reg < 4'd8)
                                && !shift_reg[7];
              2'd1: scl_oe_o <= 1'b0;
              2'd2: rx_tick_reg <= 1'b1;
              default:
              begin
                scl_oe_o    <= 1'b1;
                bit_cnt_reg <= bit_cnt_reg + 4'd1;
                if ((state_reg == ST_RX && bit_cnt_reg == 4'd7) ||
                    (state_reg == ST_TX && bit_cnt_reg == 4'd8))
                begin
                  sda_oe_o  <= 1'b0;
                  state_reg <= ST_IDLE;
                  done_ev   <= 1'b1;
                  seq_clr   <= (state_reg == ST_RX) ? sel_bit(`MSC_BIT_RXGO) : 8'h00;
                end
              end
            endcase
          end
        // slave: shift the first byte after a start, flag a general call
        ST_SLAVE:
        begin
          scl_oe_o <= 1'b0;
          sda_oe_o <= 1'b0;
          if (!slave_mode)
            state_reg <= ST_IDLE;
          else if (bus_start)
            bit_cnt_reg <= 4'd0;
          else if (scl_rise && bit_cnt_reg < 4'd8)
          begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
            if (bit_cnt_reg == 4'd7 && {shift_reg[6:0], sda_s} == 8'h00)
              gcall_ev <= seq_reg[`MSC_BIT_GCE];
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (rx_tick_reg)
        shift_reg <= {shift_reg[6:0], sda_s};
    end
  end

  // ----------------------------------------------------------------------------
  // control, status and interrupt registers
  // ----------------------------------------------------------------------------
  // while busy a write neither sets nor clears the running go bits
  wire [4:0] seq_req = seq_ok ? wdat[4:0] : seq_reg[4:0];
  // done_ev comes after the state has left, so the finished kind is read from seq_clr
  wire       rx_byte = seq_clr[`MSC_BIT_RXGO];
  wire       tx_done = done_ev && (seq_clr == 8'h00);
  wire       tx_ack  = tx_busy && baud_tick && phase_reg == 2'd2 && bit_cnt_reg == 4'd8;
  wire       ev_write_collision_flag = wr_data && !data_ok && master_mode;
  wire [`MSC_IRQ_W-1:0] irq_ev = {ev_write_collision_flag, gcall_ev, done_ev};

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mode_reg     <= 8'h00;
      seq_reg      <= `MSC_SEQ_RESET;
      baud_reg     <= `MSC_BAUD_RESET;
      data_reg     <= 8'h00;
      slv_addr_reg <= 7'h00;
      buf_full_reg <= 1'b0;
      write_collision_flag_reg     <= 1'b0;
      irq_stat_reg <= {`MSC_IRQ_W{1'b0}};
      irq_mask_reg <= {`MSC_IRQ_W{1'b0}};
      irq_o        <= 1'b0;
    end
    else
    begin
      if (wr_now && wr_addr_reg == `MSC_OFF_MODE)
      begin
        mode_reg <= {4'h0, wdat[3:0]};
        write_collision_flag_reg <= wdat[7] & write_collision_flag_reg;
      end
      if (wr_now && wr_addr_reg == `MSC_OFF_BAUD)
        baud_reg <= wdat;
      if (wr_now && wr_addr_reg == `MSC_OFF_SLV_ADDR)
        slv_addr_reg <= wdat[6:0];
      if (wr_now && wr_addr_reg == `MSC_OFF_IRQ_MASK)
        irq_mask_reg <= wdat[`MSC_IRQ_W-1:0];
      // gce, ack value and ack status freely writable; go bits only when idle
      if (wr_seq)
        seq_reg <= {wdat[7:5], seq_req} & ~seq_clr;
      else
        seq_reg <= seq_reg & ~seq_clr;
      // ack status: high when the slave left sda high in the ninth slot
      if (tx_ack)
        seq_reg[`MSC_BIT_ACK_STATUS_FLAG] <= sda_s;
      if (wr_data && data_ok)
      begin
        data_reg     <= wdat;
        buf_full_reg <= 1'b1;
      end
      else if (rx_byte)
      begin
        data_reg     <= shift_reg;
        buf_full_reg <= 1'b1;
      end
      else if (tx_done)
        buf_full_reg <= 1'b0;
      // refused buffer write in master mode flags a collision; set beats clear
      if (ev_write_collision_flag)
        write_collision_flag_reg <= 1'b1;
      // write one to clear, a new event wins over the clear
      irq_stat_reg <= (irq_stat_reg & ~(wdat[`MSC_IRQ_W-1:0] & {`MSC_IRQ_W{wr_istat}}))
                      | irq_ev;
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule // msc_seq_ctrl
